// File: rtl/jdds_core.sv
/*
 Jack detection debounce and status block with a Wishbone register port.
 Assumes comparator results synchronous to clk_in and a classic
 single-cycle Wishbone master.
*/
// Design decision made here: the Wishbone slave port.
`timescale 1ns/1ps
module jdds_core
    import jdds_pkg::*;
#(
    parameter int MS_TICK_CYCLES = MS_CYCLES
)
(
    input wire logic clk_in,
    input wire logic reset_in,
    input wire logic wb_cyc_in,
    input wire logic wb_stb_in,
    input wire logic wb_we_in,
    input wire logic [ADDR_W-1:0] wb_adr_in,
    input wire logic [3:0] wb_sel_in,
    input wire logic [31:0] wb_dat_in,
    output logic [31:0] wb_dat_out,
    output logic wb_ack_out,
    input wire jdds_raw_t raw_in,
    output logic detect_pulse_out,
    output logic sample_tick_out,
    output jdds_status_t jack_status_out,
    output logic hook_pressed_out
);
    logic wb_ack_ff;
    logic [31:0] wb_dat_ff;
    logic [7:0] timing_ff;
    logic [7:0] enable_ff;
    logic [7:0] jack_debounce_config_ff;
    logic [15:0] ms_cnt_ff;
    logic ms_tick_ff;
    logic [2:0] period_cnt_ff;
    logic sample_tick_ff;
    logic [10:0] rate_cnt_ff;
    logic detect_pulse_ff;
    logic inserted_ff;
    logic mic_ff;
    logic [9:0] ins_ms_ff;
    logic [2:0] rem_cnt_ff;
    logic [1:0] kind_cand_ff;
    logic [2:0] kind_cnt_ff;
    logic [1:0] kind_ff;
    logic hook_cand_ff;
    logic [1:0] hook_cnt_ff;
    logic hook_ff;
    jdds_status_t status_ff;
    logic detection_enable;
    logic headphone_debounce_sel;
    logic [2:0] insertion_debounce_time;
    logic removal_debounce_count;
    logic [1:0] hook_debounce_count;
    logic [1:0] detect_clock_period_sel;
    logic [1:0] detect_pulse_rate;
    logic bus_req;
    logic wr_en;
    logic [7:0] nxt_rdata;
    logic [2:0] period_len;
    logic [10:0] rate_len;
    logic [9:0] ins_len;
    logic [2:0] rem_len;
    logic [2:0] kind_len;
    logic [1:0] hook_len;
    assign detection_enable = enable_ff[ENABLE_BIT];
    assign headphone_debounce_sel = jack_debounce_config_ff[HPDEB_BIT];
    assign insertion_debounce_time = jack_debounce_config_ff[INSERT_LSB +: 3];
    assign removal_debounce_count = jack_debounce_config_ff[REMOVAL_BIT];
    assign hook_debounce_count = jack_debounce_config_ff[HOOK_LSB +: 2];
    assign detect_clock_period_sel = timing_ff[PERIOD_LSB +: 2];
    assign detect_pulse_rate = timing_ff[RATE_LSB +: 2];
    assign bus_req = wb_cyc_in && wb_stb_in && !wb_ack_ff;
    // Writes land on the edge at which the master samples ack high
    assign wr_en = wb_cyc_in && wb_stb_in && wb_ack_ff && wb_we_in && wb_sel_in[0];

    // Bus acknowledge, one cycle after the request is seen
    always_ff @(posedge clk_in or posedge reset_in)
    begin
        if (reset_in)
        begin
            wb_ack_ff <= 1'b0;
        end
        else
        begin
            wb_ack_ff <= bus_req;
        end
    end

    // Read data selection; unmapped addresses read zero
    always_comb
    begin
        if (wb_adr_in == ADDR_TIMING)
        begin
            nxt_rdata = timing_ff;
        end
        else if (wb_adr_in == ADDR_ENABLE)
        begin
            nxt_rdata = enable_ff;
        end
        else if (wb_adr_in == ADDR_DEBOUNCE)
        begin
            nxt_rdata = jack_debounce_config_ff;
        end
        else if (wb_adr_in == ADDR_STATUS)
        begin
            nxt_rdata = status_ff;
        end
        else
        begin
            nxt_rdata = 8'h00;
        end
    end

    always_ff @(posedge clk_in or posedge reset_in)
    begin
        if (reset_in)
        begin
            wb_dat_ff <= 32'h0000_0000;
        end
        else if (bus_req && !wb_we_in)
        begin
            wb_dat_ff <= {24'h00_0000, nxt_rdata};
        end
    end

    // Configuration writes; read-only and reserved bits are masked
    always_ff @(posedge clk_in or posedge reset_in)
    begin
        if (reset_in)
        begin
            timing_ff <= CFG_RESET;
            enable_ff <= CFG_RESET;
            jack_debounce_config_ff <= CFG_RESET;
        end
        else if (wr_en)
        begin
            if (wb_adr_in == ADDR_TIMING)
            begin
                timing_ff <= wb_dat_in[7:0] & TIMING_MASK;
            end
            else if (wb_adr_in == ADDR_ENABLE)
            begin
                enable_ff <= wb_dat_in[7:0] & ENABLE_MASK;
            end
            else if (wb_adr_in == ADDR_DEBOUNCE)
            begin
                jack_debounce_config_ff <= wb_dat_in[7:0] & DEBOUNCE_MASK;
            end
        end
    end

    // Millisecond timebase
    always_ff @(posedge clk_in or posedge reset_in)
    begin
        if (reset_in)
        begin
            ms_cnt_ff <= 16'h0000;
            ms_tick_ff <= 1'b0;
        end
        else if (!detection_enable || ms_cnt_ff == 16'(MS_TICK_CYCLES - 1))
        begin
            ms_cnt_ff <= 16'h0000;
            ms_tick_ff <= detection_enable;
        end
        else
        begin
            ms_cnt_ff <= ms_cnt_ff + 16'h0001;
            ms_tick_ff <= 1'b0;
        end
    end

    // Sample period of 1, 2 or 4 ms; reserved code taken as 4 ms
    always_comb
    begin
        case (detect_clock_period_sel)
            2'h0: period_len = 3'h1;
            2'h1: period_len = 3'h2;
            default: period_len = 3'h4;
        endcase
    end

    always_ff @(posedge clk_in or posedge reset_in)
    begin
        if (reset_in)
        begin
            period_cnt_ff <= 3'h0;
            sample_tick_ff <= 1'b0;
        end
        else if (!detection_enable)
        begin
            period_cnt_ff <= 3'h0;
            sample_tick_ff <= 1'b0;
        end
        else if (ms_tick_ff && period_cnt_ff + 3'h1 >= period_len)
        begin
            period_cnt_ff <= 3'h0;
            sample_tick_ff <= 1'b1;
        end
        else
        begin
            period_cnt_ff <= period_cnt_ff + {2'h0, ms_tick_ff};
            sample_tick_ff <= 1'b0;
        end
    end

    // Detection pulse rate
    always_comb
    begin
        case (detect_pulse_rate)
            2'h0: rate_len = RATE_0_MS;
            2'h1: rate_len = RATE_1_MS;
            2'h2: rate_len = RATE_2_MS;
            default: rate_len = RATE_3_MS;
        endcase
    end

    always_ff @(posedge clk_in or posedge reset_in)
    begin
        if (reset_in)
        begin
            rate_cnt_ff <= 11'h000;
            detect_pulse_ff <= 1'b0;
        end
        else if (!detection_enable)
        begin
            rate_cnt_ff <= 11'h000;
            detect_pulse_ff <= 1'b0;
        end
        else if (ms_tick_ff && rate_cnt_ff + 11'h001 >= rate_len)
        begin
            rate_cnt_ff <= 11'h000;
            detect_pulse_ff <= 1'b1;
        end
        else
        begin
            rate_cnt_ff <= rate_cnt_ff + {10'h000, ms_tick_ff};
            detect_pulse_ff <= 1'b0;
        end
    end

    // Debounce lengths
    assign ins_len = INSERT_BASE_MS << insertion_debounce_time;
    assign rem_len = removal_debounce_count ? REMOVE_COUNT_FAST : REMOVE_COUNT_SLOW;
    assign kind_len = headphone_debounce_sel ? HP_DEB_COUNT : 3'h1;
    assign hook_len = (hook_debounce_count < 2'h2) ? 2'h1 : hook_debounce_count;

    // Jack insertion (timed) and removal (counted)
    always_ff @(posedge clk_in or posedge reset_in)
    begin
        if (reset_in)
        begin
            inserted_ff <= 1'b0;
            mic_ff <= 1'b0;
            ins_ms_ff <= 10'h000;
            rem_cnt_ff <= 3'h0;
        end
        else if (!detection_enable)
        begin
            ins_ms_ff <= 10'h000;
            rem_cnt_ff <= 3'h0;
        end
        else if (!inserted_ff)
        begin
            rem_cnt_ff <= 3'h0;
            if (!raw_in.jack)
            begin
                ins_ms_ff <= 10'h000;
            end
            else if (insertion_debounce_time == INSERT_NONE
                     || (ms_tick_ff && ins_ms_ff + 10'h001 >= ins_len))
            begin
                inserted_ff <= 1'b1;
                mic_ff <= raw_in.mic;
                ins_ms_ff <= 10'h000;
            end
            else
            begin
                ins_ms_ff <= ins_ms_ff + {9'h000, ms_tick_ff};
            end
        end
        else
        begin
            ins_ms_ff <= 10'h000;
            if (raw_in.jack)
            begin
                rem_cnt_ff <= 3'h0;
            end
            else if (sample_tick_ff && rem_cnt_ff + 3'h1 >= rem_len)
            begin
                inserted_ff <= 1'b0;
                mic_ff <= 1'b0;
                rem_cnt_ff <= 3'h0;
            end
            else
            begin
                rem_cnt_ff <= rem_cnt_ff + {2'h0, sample_tick_ff};
            end
        end
    end

    // Headphone kind result debounce
    always_ff @(posedge clk_in or posedge reset_in)
    begin
        if (reset_in)
        begin
            kind_cand_ff <= KIND_NONE;
            kind_cnt_ff <= 3'h0;
            kind_ff <= KIND_NONE;
        end
        else if (detection_enable && sample_tick_ff)
        begin
            if (raw_in.kind != kind_cand_ff)
            begin
                kind_cand_ff <= raw_in.kind;
                kind_cnt_ff <= 3'h1;
                if (kind_len == 3'h1)
                begin
                    kind_ff <= raw_in.kind;
                end
            end
            else if (kind_cnt_ff + 3'h1 >= kind_len)
            begin
                kind_ff <= kind_cand_ff;
                kind_cnt_ff <= kind_len;
            end
            else
            begin
                kind_cnt_ff <= kind_cnt_ff + 3'h1;
            end
        end
    end

    // Hook press debounce
    always_ff @(posedge clk_in or posedge reset_in)
    begin
        if (reset_in)
        begin
            hook_cand_ff <= 1'b0;
            hook_cnt_ff <= 2'h0;
            hook_ff <= 1'b0;
        end
        else if (detection_enable && sample_tick_ff)
        begin
            if (raw_in.hook != hook_cand_ff)
            begin
                hook_cand_ff <= raw_in.hook;
                hook_cnt_ff <= 2'h1;
                if (hook_len == 2'h1)
                begin
                    hook_ff <= raw_in.hook;
                end
            end
            else if (hook_cnt_ff + 2'h1 >= hook_len)
            begin
                hook_ff <= hook_cand_ff;
                hook_cnt_ff <= hook_len;
            end
            else
            begin
                hook_cnt_ff <= hook_cnt_ff + 2'h1;
            end
        end
    end

    // Status register; value 2 is never produced
    always_ff @(posedge clk_in or posedge reset_in)
    begin
        if (reset_in)
        begin
            status_ff <= STATUS_RESET;
        end
        else if (detection_enable)
        begin
            status_ff.jack_type <= !inserted_ff ? JACK_NONE : (mic_ff ? JACK_MIC : JACK_NO_MIC);
            status_ff.kind <= inserted_ff ? kind_ff : KIND_NONE;
            status_ff.zero <= 4'h0;
        end
    end

    // Registered outputs
    always_ff @(posedge clk_in or posedge reset_in)
    begin
        if (reset_in)
        begin
            hook_pressed_out <= 1'b0;
            jack_status_out <= STATUS_RESET;
            detect_pulse_out <= 1'b0;
            sample_tick_out <= 1'b0;
        end
        else
        begin
            hook_pressed_out <= hook_ff && inserted_ff;
            jack_status_out <= status_ff;
            detect_pulse_out <= detect_pulse_ff;
            sample_tick_out <= sample_tick_ff;
        end
    end

    assign wb_ack_out = wb_ack_ff;
    assign wb_dat_out = wb_dat_ff;
endmodule

// File: rtl/jdds_pkg.sv
/*
 Constants, register map and carrier types for the jack detection
 debounce and status block.
 Assumes a 50 MHz clock and a 32-bit classic Wishbone slave port.
*/
// Notes on behaviour
// - Headphone result debounce off, or three detections
// - Insertion debounce 16..512 ms for codes 0-5; code 6 ends at the next 1 ms tick; code 7 none
// - Removal needs five detections, or three
// - Hook debounce none, two or three detections
// - Jack state field bits 7-6, values 0,1,3
// - Jack state never reports value 2
// - Headset type field bits 5-4
// - Reserved status bits read zero, writes ignored
// - Jack status resets to zero
// - Detection and status updates only when enabled
// - Detection sample period 1, 2 or 4 ms
// - Detection pulse rate 0.5, 1, 7.5, 15 Hz
package jdds_pkg;
    localparam logic [7:0] IDX_TIMING = 8'h19;
    localparam logic [7:0] IDX_ENABLE = 8'h1a;
    localparam logic [7:0] IDX_DEBOUNCE = 8'h1b;
    localparam logic [7:0] IDX_STATUS = 8'h1c;
    localparam int ADDR_W = 10;
    localparam logic [ADDR_W-1:0] ADDR_TIMING = {IDX_TIMING, 2'b00};
    localparam logic [ADDR_W-1:0] ADDR_ENABLE = {IDX_ENABLE, 2'b00};
    localparam logic [ADDR_W-1:0] ADDR_DEBOUNCE = {IDX_DEBOUNCE, 2'b00};
    localparam logic [ADDR_W-1:0] ADDR_STATUS = {IDX_STATUS, 2'b00};
    // Field positions
    localparam int RATE_LSB = 6;
    localparam int PERIOD_LSB = 1;
    localparam int ENABLE_BIT = 1;
    localparam int HPDEB_BIT = 6;
    localparam int INSERT_LSB = 3;
    localparam int REMOVAL_BIT = 2;
    localparam int HOOK_LSB = 0;
    // Writable masks and reset values
    localparam logic [7:0] TIMING_MASK = 8'hc6;
    localparam logic [7:0] ENABLE_MASK = 8'h02;
    localparam logic [7:0] DEBOUNCE_MASK = 8'h7f;
    localparam logic [7:0] CFG_RESET = 8'h00;
    localparam logic [7:0] STATUS_RESET = 8'h00;
    // Encodings
    localparam logic [2:0] INSERT_NONE = 3'h7;
    localparam logic [1:0] JACK_NONE = 2'h0;
    localparam logic [1:0] JACK_NO_MIC = 2'h1;
    localparam logic [1:0] JACK_MIC = 2'h3;
    localparam logic [1:0] KIND_NONE = 2'h0;
    // Detection counts
    localparam logic [2:0] HP_DEB_COUNT = 3'h3;
    localparam logic [2:0] REMOVE_COUNT_SLOW = 3'h5;
    localparam logic [2:0] REMOVE_COUNT_FAST = 3'h3;
    // Timing
    localparam int CLK_PERIOD_NS = 20;
    localparam int MS_NS = 1000000;
    localparam int MS_CYCLES = MS_NS / CLK_PERIOD_NS;
    localparam logic [10:0] RATE_0_MS = 11'h7d0;
    localparam logic [10:0] RATE_1_MS = 11'h3e8;
    localparam logic [10:0] RATE_2_MS = 11'h085;
    localparam logic [10:0] RATE_3_MS = 11'h042;
    localparam logic [9:0] INSERT_BASE_MS = 10'h010;
    typedef struct packed {
        logic jack;
        logic mic;
        logic [1:0] kind;
        logic hook;
    } jdds_raw_t;
    typedef struct packed {
        logic [1:0] jack_type;
        logic [1:0] kind;
        logic [3:0] zero;
    } jdds_status_t;
endpackage

// File: tb/jdds_comparator_model.sv
/*
 Behavioural model of the analog jack and hook comparators.
 Assumes levels are set by the bench; bounce_in makes the jack contact chatter.
*/
`timescale 1ns/1ps
module jdds_comparator_model
    import jdds_pkg::*;
(
    input wire logic clk_in,
    input wire logic reset_in,
    input wire jdds_raw_t level_in,
    input wire logic bounce_in,
    output jdds_raw_t raw_out
);
    // Comparator outputs settle one clock after the level changes
    always_ff @(posedge clk_in or posedge reset_in)
    begin
        if (reset_in)
            raw_out <= '0;
        else if (bounce_in)
            raw_out.jack <= !raw_out.jack;
        else
            raw_out <= level_in;
    end
endmodule

// File: tb/jdds_monitor.sv
/*
 Port checker for jdds_core.
 Bound to every jdds_core instance; sees only its ports.
*/
`timescale 1ns/1ps
module jdds_monitor
    import jdds_pkg::*;
(
    input wire logic clk_in,
    input wire logic reset_in,
    input wire logic wb_cyc_in,
    input wire logic wb_stb_in,
    input wire logic wb_we_in,
    input wire logic [ADDR_W-1:0] wb_adr_in,
    input wire logic [31:0] wb_dat_out,
    input wire logic wb_ack_out,
    input wire jdds_raw_t raw_in,
    input wire logic detect_pulse_out,
    input wire logic sample_tick_out,
    input wire jdds_status_t jack_status_out,
    input wire logic hook_pressed_out
);
    logic [2:0] low_ticks_ff;
    logic [2:0] nxt_low_ticks;
    default clocking @(posedge clk_in); endclocking
    default disable iff (reset_in);
    // Sample ticks seen since the raw jack line last went low
    always_comb
    begin
        nxt_low_ticks = low_ticks_ff;
        if (raw_in.jack)
            nxt_low_ticks = 3'h0;
        else if (sample_tick_out && low_ticks_ff != 3'h7)
            nxt_low_ticks = low_ticks_ff + 3'h1;
    end
    always_ff @(posedge clk_in or posedge reset_in)
    begin
        if (reset_in)
            low_ticks_ff <= 3'h0;
        else
            low_ticks_ff <= nxt_low_ticks;
    end
    property p_ack_next;
        wb_cyc_in && wb_stb_in && !wb_ack_out |=> wb_ack_out;
    endproperty
    a_ack_next: assert property (p_ack_next) else $error("ack late");
    property p_ack_pulse;
        wb_ack_out |=> !wb_ack_out;
    endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
    property p_rd_status;
        wb_cyc_in && wb_stb_in && !wb_ack_out && !wb_we_in && wb_adr_in == ADDR_STATUS
            |=> wb_dat_out == {24'h0, jack_status_out};
    endproperty
    a_rd_status: assert property (p_rd_status) else $error("status read wrong");
    property p_no_jack2;
        jack_status_out.jack_type != 2'h2;
    endproperty
    a_no_jack2: assert property (p_no_jack2) else $error("jack type 2");
    property p_rsvd_zero;
        jack_status_out.zero == 4'h0;
    endproperty
    a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved bits set");
    property p_kind_needs_jack;
        jack_status_out.jack_type == JACK_NONE |-> jack_status_out.kind == KIND_NONE;
    endproperty
    a_kind_needs_jack: assert property (p_kind_needs_jack) else $error("kind without jack");
    property p_hook_needs_jack;
        $rose(hook_pressed_out) |=> jack_status_out.jack_type != JACK_NONE;
    endproperty
    a_hook_needs_jack: assert property (p_hook_needs_jack) else $error("hook without jack");
    property p_removal_count;
        $fell(jack_status_out.jack_type[0]) |-> low_ticks_ff >= 3'h3;
    endproperty
    a_removal_count: assert property (p_removal_count) else $error("removal too early");
    property p_tick_pulse;
        sample_tick_out |=> !sample_tick_out;
    endproperty
    a_tick_pulse: assert property (p_tick_pulse) else $error("tick too long");
    property p_pulse_single;
        detect_pulse_out |=> !detect_pulse_out;
    endproperty
    a_pulse_single: assert property (p_pulse_single) else $error("pulse too long");
    c_read: cover property (wb_ack_out && !wb_we_in);
    c_mic: cover property (jack_status_out.jack_type == JACK_MIC);
    c_hook: cover property ($rose(hook_pressed_out));
endmodule
bind jdds_core jdds_monitor u_mon (.clk_in(clk_in), .reset_in(reset_in), .wb_cyc_in(wb_cyc_in),
    .wb_stb_in(wb_stb_in), .wb_we_in(wb_we_in), .wb_adr_in(wb_adr_in), .wb_dat_out(wb_dat_out),
    .wb_ack_out(wb_ack_out), .raw_in(raw_in), .detect_pulse_out(detect_pulse_out),
    .sample_tick_out(sample_tick_out), .jack_status_out(jack_status_out),
    .hook_pressed_out(hook_pressed_out));

// File: tb/test_jack_detect_debounce_status.sv
/*
 Self-checking testbench for jdds_core.
 Assumes a 50 MHz clock and the comparator model on raw_in.
*/
`timescale 1ns/1ps
module test_jack_detect_debounce_status;
    import jdds_pkg::*;
    localparam int MS = 5;
    logic clk_in = 1'b0;
    logic reset_in = 1'b1;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [ADDR_W-1:0] adr = '0;
    logic [3:0] sel = 4'h0;
    logic [31:0] wdat = '0;
    logic [31:0] rdat;
    logic ack, hook, tick, pulse, bounce;
    jdds_status_t stat;
    jdds_raw_t lvl, raw;
    logic [31:0] exp_q[$];
    int miscompares = 0;
    int checked = 0;
    int c, b, n, t;
    logic [31:0] r;
    logic [7:0] cfg;
    logic [1:0] k;
    always #10 clk_in = ~clk_in;
    jdds_core #(.MS_TICK_CYCLES(MS)) DUT (.clk_in(clk_in), .reset_in(reset_in), .wb_cyc_in(cyc),
        .wb_stb_in(stb), .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(sel), .wb_dat_in(wdat),
        .wb_dat_out(rdat), .wb_ack_out(ack), .raw_in(raw), .detect_pulse_out(pulse),
        .sample_tick_out(tick), .jack_status_out(stat), .hook_pressed_out(hook));
    jdds_comparator_model u_model (.clk_in(clk_in), .reset_in(reset_in), .level_in(lvl),
        .bounce_in(bounce), .raw_out(raw));
    task test_done;
    begin
        if (exp_q.size() != 0)
        begin
            $display("BAD %0t %s", $time, "reads missing");
            miscompares++;
        end
        $display("counts: checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    end
    endtask
    task bad(input string m);
    begin
        $display("BAD %0t %s", $time, m);
        miscompares++;
    end
    endtask
    task bus(input logic w, input logic [ADDR_W-1:0] a, input logic [7:0] d, input logic [3:0] s);
        int i;
    begin
        @(posedge clk_in);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        sel <= s;
        wdat <= {24'h0, d};
        i = 0;
        do
        begin
            @(posedge clk_in);
            i++;
        end
        while (ack !== 1'b1 && i < 20);
        if (ack !== 1'b1)
        begin
            bad("no ack");
            test_done;
        end
        cyc <= 1'b0;
        stb <= 1'b0;
    end
    endtask
    task rd(input logic [ADDR_W-1:0] a, input logic [7:0] e);
    begin
        exp_q.push_back({24'h0, e});
        bus(1'b0, a, 8'h00, 4'hf);
    end
    endtask
    task wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
    begin
        bus(1'b1, a, d, 4'h1);
    end
    endtask
    // Cycles between two pulses of the tick (p=0) or the detection pulse (p=1)
    task gap(input logic p, input int e);
        int g;
    begin
        g = 0;
        while ((p ? pulse : tick) !== 1'b1 && g < 4000)
        begin
            @(posedge clk_in);
            g++;
        end
        g = 0;
        do
        begin
            @(posedge clk_in);
            g++;
        end
        while ((p ? pulse : tick) !== 1'b1 && g < 4000);
        checked++;
        if (g != e)
            bad("pulse spacing");
    end
    endtask
    task hook_is(input logic e);
    begin
        checked++;
        if (hook !== e)
            bad("hook level");
    end
    endtask
    // Takes the oldest expected read value whenever a read is answered
    always @(posedge clk_in)
    begin
        if (ack === 1'b1 && we === 1'b0)
        begin
            checked++;
            if (exp_q.size() == 0)
                bad("unexpected read");
            else if (rdat !== exp_q.pop_front())
                bad("read data");
        end
    end
    initial
    begin
        lvl = '0;
        bounce = 1'b0;
        r = $urandom(32'hbf70e6c6);
        r = $urandom();
        repeat (4) @(posedge clk_in);
        reset_in <= 1'b0;
        rd(ADDR_STATUS, STATUS_RESET);
        rd(ADDR_DEBOUNCE, CFG_RESET);
        wr(ADDR_STATUS, 8'hff);
        rd(ADDR_STATUS, 8'h00);
        rd(10'h3fc, 8'h00);
        cfg = r[7:0];
        if (cfg[5:3] == 3'h6)
            cfg[5:3] = INSERT_NONE;
        wr(ADDR_DEBOUNCE, cfg);
        rd(ADDR_DEBOUNCE, cfg & DEBOUNCE_MASK);
        bus(1'b1, ADDR_DEBOUNCE, ~cfg, 4'h0);
        rd(ADDR_DEBOUNCE, cfg & DEBOUNCE_MASK);
        wr(ADDR_TIMING, 8'hff);
        rd(ADDR_TIMING, TIMING_MASK);
        wr(ADDR_TIMING, 8'h00);
        $display("test registers done");
        wr(ADDR_DEBOUNCE, 8'h3f);
        lvl <= '{1'b1, 1'b1, 2'h3, 1'b0};
        repeat (40) @(posedge clk_in);
        rd(ADDR_STATUS, 8'h00);
        wr(ADDR_ENABLE, 8'h02);
        repeat (6 * MS) @(posedge clk_in);
        rd(ADDR_STATUS, 8'hf0);
        lvl.hook <= 1'b1;
        repeat (MS) @(posedge clk_in);
        hook_is(1'b0);
        repeat (5 * MS) @(posedge clk_in);
        hook_is(1'b1);
        lvl.hook <= 1'b0;
        $display("test enable and hook done");
        for (b = 0; b < 2; b++)
        begin
            n = b ? 3 : 5;
            wr(ADDR_DEBOUNCE, {2'b00, INSERT_NONE, b[0], 2'h3});
            lvl.jack <= 1'b1;
            repeat (4 * MS) @(posedge clk_in);
            rd(ADDR_STATUS, 8'hf0);
            lvl.jack <= 1'b0;
            repeat (MS * (n - 2)) @(posedge clk_in);
            rd(ADDR_STATUS, 8'hf0);
            repeat (MS * 4) @(posedge clk_in);
            rd(ADDR_STATUS, 8'h00);
        end
        $display("test removal done");
        for (c = 0; c < 6; c++)
        begin
            k = 2'(c % 3 + 1);
            wr(ADDR_DEBOUNCE, {1'b0, c[0], c[2:0], 1'b1, 2'h0});
            lvl <= '{1'b1, 1'b0, k, 1'b0};
            if (c == 0)
            begin
                bounce <= 1'b1;
                repeat (30) @(posedge clk_in);
                bounce <= 1'b0;
            end
            t = MS * (16 << c);
            repeat (t - 10) @(posedge clk_in);
            rd(ADDR_STATUS, 8'h00);
            repeat (30) @(posedge clk_in);
            rd(ADDR_STATUS, {JACK_NO_MIC, k, 4'h0});
            lvl.jack <= 1'b0;
            repeat (8 * MS) @(posedge clk_in);
            rd(ADDR_STATUS, 8'h00);
        end
        $display("test insertion debounce done");
        wr(ADDR_TIMING, {2'h3, 3'h0, 2'h1, 1'b0});
        gap(1'b0, 2 * MS);
        gap(1'b1, MS * int'(RATE_3_MS));
        $display("test rates done");
        repeat (4) @(posedge clk_in);
        test_done;
    end
endmodule
